// ---- verilog/owlpr_defines.svh ----
// Constants for the one-wire level program receiver.
// Function
// R1 - Bytes arrive most significant bit first, least significant bit last.
// R2 - Host holds line high at least the lead-high time before each byte.
// R3 - Lead-high before the address byte may be omitted if line rests high.
// R4 - A high end-of-stream phase of byte-end time completes each byte; the code times a low end-of-stream phase instead.
// R5 - One when high is at least twice low; zero when low twice high.
// R6 - Each bit is measured from one falling edge to the next.
// R7 - Acknowledge only with request flag, matching address, sixteen good bits.
// R8 - After a delay past last falling edge, pull line low up to 512 us.
// R9 - Host keeps line low through the delay, then releases and samples.
// R10 - Host waits for line release before starting a new transmission.
// R11 - Acknowledge is active-low open drain; host provides the pull-up.
// R12 - A push-pull host never sets the acknowledge request flag.
// R13 - Data byte holds request flag, two zero sub-address bits, level code.
// R14 - Level code register resets to full scale, code 31.
// R15 - Bits decode for any rate from 1.7 to 160 kbit/s unconfigured.
// R16 - Level code updates only on complete sixteen-bit frames with address.
`ifndef OWLPR_DEFINES_SVH
`define OWLPR_DEFINES_SVH
`define OWLPR_CLK_MHZ 200
`define OWLPR_BYTE_END_NS 2000
`define OWLPR_BYTE_END_CYC (`OWLPR_BYTE_END_NS * `OWLPR_CLK_MHZ / 1000)
`define OWLPR_REPLY_DELAY_NS 1000
`define OWLPR_REPLY_DELAY_CYC (`OWLPR_REPLY_DELAY_NS * `OWLPR_CLK_MHZ / 1000)
`define OWLPR_REPLY_PULSE_US 400
`define OWLPR_REPLY_PULSE_CYC (`OWLPR_REPLY_PULSE_US * `OWLPR_CLK_MHZ)
`define OWLPR_CNT_W 20
`define OWLPR_CNT_MAX 20'hFFFFF
// The device address value is arbitrary.
`define OWLPR_DEV_ADDR 8'h5A
`define OWLPR_LEVEL_RESET 5'h1F
`define OWLPR_FLAG_BIT 7
`define OWLPR_SUB_HI_BIT 6
`define OWLPR_SUB_LO_BIT 5
`define OWLPR_LEVEL_MSB 4
`define OWLPR_BITS_PER_BYTE 4'h8
`endif

// ---- verilog/owlpr_pkg.sv ----
// Types shared by the one-wire level program receiver.
package owlpr_pkg;
  typedef enum logic [2:0] {
    OWLPR_IDLE = 3'b000,
    OWLPR_LOW = 3'b001,
    OWLPR_HIGH = 3'b011,
    OWLPR_WAIT = 3'b010,
    OWLPR_REPLY = 3'b110
  } owlpr_state_type;
endpackage

// ---- verilog/owlpr_bus_if.sv ----
// Interface carrying the decoded bit stream to the byte assembler.
`timescale 1ns/1ps
`default_nettype none
interface owlpr_bus_if;
  logic bit_valid;
  logic bit_value;
  logic byte_end;
  logic frame_abort;
  modport src(output bit_valid, output bit_value, output byte_end,
    output frame_abort);
  modport dst(input bit_valid, input bit_value, input byte_end,
    input frame_abort);
endinterface
`default_nettype wire

// ---- verilog/owlpr_assembler.sv ----
// Byte assembler that gathers address and data bytes into a frame.
`timescale 1ns/1ps
`default_nettype none
`include "owlpr_defines.svh"
module owlpr_assembler (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  owlpr_bus_if.dst bus,
  output logic frame_ok,
  output logic [7:0] frame_data
);
  logic [7:0] shift_reg, shift_next;
  logic [3:0] count_reg, count_next;
  logic second_reg, second_next;
  logic addr_ok_reg, addr_ok_next;
  logic ok_reg, ok_next;
  logic [7:0] data_reg, data_next;

  always_comb begin
    shift_next = shift_reg;
    count_next = count_reg;
    second_next = second_reg;
    addr_ok_next = addr_ok_reg;
    ok_next = 1'b0;
    data_next = data_reg;
    if (bus.frame_abort) begin
      count_next = 4'h0;
      second_next = 1'b0;
    end else if (bus.bit_valid) begin
      shift_next = {shift_reg[6:0], bus.bit_value}; // R1
      count_next = count_reg + 4'h1;
    end else if (bus.byte_end) begin
      count_next = 4'h0; // R4
      if (count_reg != `OWLPR_BITS_PER_BYTE) begin
        second_next = 1'b0; // R16
      end else if (!second_reg) begin
        addr_ok_next = (shift_reg == `OWLPR_DEV_ADDR);
        second_next = 1'b1;
      end else begin
        second_next = 1'b0;
        ok_next = addr_ok_reg; // R16
        data_next = shift_reg;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      shift_reg <= 8'h00;
      count_reg <= 4'h0;
      second_reg <= 1'b0;
      addr_ok_reg <= 1'b0;
      ok_reg <= 1'b0;
      data_reg <= 8'h00;
    end else if (ce) begin
      shift_reg <= shift_next;
      count_reg <= count_next;
      second_reg <= second_next;
      addr_ok_reg <= addr_ok_next;
      ok_reg <= ok_next;
      data_reg <= data_next;
    end
  end

  assign frame_ok = ok_reg;
  assign frame_data = data_reg;
endmodule
`default_nettype wire

// ---- verilog/owlpr_receiver.sv ----
// Top of the one-wire level program receiver.
`timescale 1ns/1ps
`default_nettype none
`include "owlpr_defines.svh"
module owlpr_receiver #(
  parameter logic [19:0] REPLY_PULSE_CYC = 20'(`OWLPR_REPLY_PULSE_CYC)
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic ctrl_in,
  output logic ctrl_out,
  output logic ctrl_oe,
  output logic [4:0] level_code,
  output logic level_update
);
  logic [19:0] low_cnt_reg, low_cnt_next;
  logic [19:0] high_cnt_reg, high_cnt_next;
  logic [19:0] tmr_reg, tmr_next;
  logic line_reg;
  owlpr_pkg::owlpr_state_type st_reg, st_next;
  logic oe_reg, oe_next;
  logic [4:0] level_reg, level_next;
  logic upd_reg, upd_next;
  logic pend_reg, pend_next;
  logic [3:0] bits_reg, bits_next;
  logic frame_ok;
  logic [7:0] frame_data;
  owlpr_bus_if bus();

  function automatic logic [19:0] sat_inc(input logic [19:0] v);
    sat_inc = (v == `OWLPR_CNT_MAX) ? v : v + 20'h1;
  endfunction

  wire fall = line_reg & ~ctrl_in; // R6
  // A bit is only counted when one phase dominates by two; the ambiguous
  // middle range aborts the frame rather than guess.
  wire is_one = high_cnt_reg >= {low_cnt_reg[18:0], 1'b0}; // R5
  wire is_zero = low_cnt_reg >= {high_cnt_reg[18:0], 1'b0}; // R5
  always_comb begin
    st_next = st_reg;
    low_cnt_next = low_cnt_reg;
    high_cnt_next = high_cnt_reg;
    tmr_next = tmr_reg;
    bits_next = bits_reg;
    oe_next = 1'b0;
    bus.bit_valid = 1'b0;
    bus.bit_value = 1'b0;
    bus.byte_end = 1'b0;
    bus.frame_abort = 1'b0;
    case (st_reg)
      owlpr_pkg::OWLPR_IDLE: begin
        // Line resting high stands in for the lead-high phase.
        if (fall) begin // R2 R3
          st_next = owlpr_pkg::OWLPR_LOW;
          low_cnt_next = 20'h1;
          high_cnt_next = 20'h0;
          bits_next = 4'h0;
        end
      end
      owlpr_pkg::OWLPR_LOW: begin
        // A saturated phase is far beyond the slowest legal bit, so a
        // cut frame is dropped there instead of waiting for ever.
        if (ctrl_in) begin
          st_next = owlpr_pkg::OWLPR_HIGH;
          high_cnt_next = 20'h1;
        end else if (low_cnt_reg == `OWLPR_CNT_MAX) begin
          bus.frame_abort = 1'b1;
          st_next = owlpr_pkg::OWLPR_IDLE;
        end else begin
          low_cnt_next = sat_inc(low_cnt_reg);
        end
      end
      owlpr_pkg::OWLPR_HIGH: begin
        high_cnt_next = sat_inc(high_cnt_reg);
        if (fall) begin
          low_cnt_next = 20'h1;
          // Bits are timed only by ratio, so any rate in range works.
          if (is_one || is_zero) begin // R15
            bus.bit_valid = 1'b1; // R6
            bus.bit_value = is_one; // R5
            bits_next = bits_reg + 4'h1;
            st_next = owlpr_pkg::OWLPR_LOW;
            if (bits_reg == `OWLPR_BITS_PER_BYTE - 4'h1) begin
              bits_next = 4'h0;
              st_next = owlpr_pkg::OWLPR_WAIT;
            end
          end else begin
            bus.frame_abort = 1'b1;
            st_next = owlpr_pkg::OWLPR_IDLE;
          end
        end else if (high_cnt_reg == `OWLPR_CNT_MAX) begin
          bus.frame_abort = 1'b1;
          st_next = owlpr_pkg::OWLPR_IDLE;
        end
      end
      owlpr_pkg::OWLPR_WAIT: begin
        // The fall after the eighth bit opens the low end-of-stream phase.
        if (ctrl_in) begin
          st_next = owlpr_pkg::OWLPR_IDLE;
          if (low_cnt_reg < 20'(`OWLPR_BYTE_END_CYC)) begin
            bus.frame_abort = 1'b1; // R4
          end
        end else begin
          low_cnt_next = sat_inc(low_cnt_reg);
          if (low_cnt_reg == 20'(`OWLPR_BYTE_END_CYC)) begin
            bus.byte_end = 1'b1; // R4
          end
          if (pend_reg && low_cnt_reg >= 20'(`OWLPR_REPLY_DELAY_CYC)) begin
            st_next = owlpr_pkg::OWLPR_REPLY; // R8 R9
            tmr_next = 20'h0;
          end
        end
      end
      owlpr_pkg::OWLPR_REPLY: begin
        oe_next = 1'b1; // R11
        tmr_next = tmr_reg + 20'h1;
        if (tmr_reg >= REPLY_PULSE_CYC) begin
          oe_next = 1'b0; // R8
          st_next = owlpr_pkg::OWLPR_IDLE;
        end
      end
      default: begin
        st_next = owlpr_pkg::OWLPR_IDLE;
      end
    endcase
  end

  always_comb begin
    level_next = level_reg;
    upd_next = 1'b0;
    pend_next = pend_reg;
    if (st_reg == owlpr_pkg::OWLPR_REPLY) begin
      pend_next = 1'b0;
    end
    if (frame_ok) begin
      level_next = frame_data[`OWLPR_LEVEL_MSB:0]; // R13 R16
      upd_next = 1'b1;
      pend_next = frame_data[`OWLPR_FLAG_BIT]; // R7 R12
    end else if (st_reg == owlpr_pkg::OWLPR_HIGH && fall) begin
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= owlpr_pkg::OWLPR_IDLE;
      low_cnt_reg <= 20'h0;
      high_cnt_reg <= 20'h0;
      tmr_reg <= 20'h0;
      line_reg <= 1'b1;
      oe_reg <= 1'b0;
      level_reg <= `OWLPR_LEVEL_RESET; // R14
      upd_reg <= 1'b0;
      pend_reg <= 1'b0;
      bits_reg <= 4'h0;
    end else if (ce) begin
      bits_reg <= bits_next;
      st_reg <= st_next;
      low_cnt_reg <= low_cnt_next;
      high_cnt_reg <= high_cnt_next;
      tmr_reg <= tmr_next;
      line_reg <= ctrl_in;
      oe_reg <= oe_next;
      level_reg <= level_next;
      upd_reg <= upd_next;
      pend_reg <= pend_next;
    end
  end

  owlpr_assembler u_asm (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .bus(bus),
    .frame_ok(frame_ok),
    .frame_data(frame_data)
  );

  assign ctrl_out = 1'b0;
  assign ctrl_oe = oe_reg;
  assign level_code = level_reg;
  assign level_update = upd_reg;
endmodule
`default_nettype wire

// ---- dv/owlpr_asserts.sv ----
// Port-level assertions for the level program receiver.
`timescale 1ns/1ps
`default_nettype none
module owlpr_asserts #(parameter logic [19:0] REPLY_PULSE_CYC = 20'h00032) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ctrl_in,
  input wire logic ctrl_out,
  input wire logic ctrl_oe,
  input wire logic [4:0] level_code,
  input wire logic level_update
);
  logic [19:0] lo_n, oe_n;
  logic upd_seen;
  // Run lengths are taken on the wire, so they bound the design's delays.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lo_n <= 20'h00000;
      oe_n <= 20'h00000;
    end else begin
      lo_n <= ctrl_in ? 20'h00000 : lo_n + 20'h00001;
      oe_n <= ctrl_oe ? oe_n + 20'h00001 : 20'h00000;
    end
    upd_seen <= !srst && (level_update || (upd_seen && !ctrl_oe));
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  od_drive_a: assert property (ctrl_out == 1'b0)
    else $error("data not low");
  reply_wait_a: assert property ($rose(ctrl_oe) |-> lo_n >= 20'h000C8)
    else $error("reply early");
  reply_len_a: assert property ($fell(ctrl_oe) |-> oe_n == REPLY_PULSE_CYC)
    else $error("reply length");
  reply_max_a: assert property (oe_n <= REPLY_PULSE_CYC)
    else $error("reply too long");
  upd_pulse_a: assert property (level_update |=> !level_update)
    else $error("update too long");
  code_hold_a: assert property ($changed(level_code) |-> level_update)
    else $error("code moved");
  byte_end_a: assert property (level_update |-> lo_n >= 20'h00190)
    else $error("update early");
  reply_frame_a: assert property ($rose(ctrl_oe) |-> upd_seen)
    else $error("reply unframed");
  cover property (level_update);
  cover property ($rose(ctrl_oe));
  cover property ($fell(ctrl_oe));
endmodule
bind owlpr_receiver owlpr_asserts #(.REPLY_PULSE_CYC(REPLY_PULSE_CYC)) u_chk (
  .core_clk(core_clk), .srst(srst), .ctrl_in(ctrl_in), .ctrl_out(ctrl_out),
  .ctrl_oe(ctrl_oe), .level_code(level_code), .level_update(level_update));
`default_nettype wire

// ---- dv/owlpr_host.sv ----
// Host model that drives the control line open drain.
`timescale 1ns/1ps
`default_nettype none
module owlpr_host (
  input wire logic core_clk,
  input wire logic dev_oe,
  output logic line
);
  logic drive_low = 1'b0;
  // Both sides only pull low, so a reply can never fight the host.
  assign line = !(drive_low || dev_oe);
  task automatic hold(input logic low, input int n);
    drive_low = low;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // The low end-of-stream also covers the reply delay for the probe.
  task automatic send_byte(input logic [7:0] b, input int n, input int lo);
    hold(1'b0, 450);
    for (int i = 7; i > 7 - n; i--) begin
      hold(1'b1, b[i] ? lo : 3 * lo);
      hold(1'b0, b[i] ? 3 * lo : lo);
    end
    hold(1'b1, 420);
  endtask
  task automatic ack(output logic seen);
    hold(1'b0, 3);
    seen = line;
    hold(1'b0, 450);
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the level program receiver.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic srst = 1'b1, ce = 1'b1;
  logic ctrl_out, ctrl_oe, level_update, seen;
  logic [4:0] level_code;
  wire line;
  int bad_count = 0, checks = 0, cyc = 0;
  initial forever #2.5 core_clk = ~core_clk;
  owlpr_receiver #(.REPLY_PULSE_CYC(20'h00032)) u_owlpr_receiver (
    .core_clk(core_clk), .srst(srst), .ce(ce), .ctrl_in(line),
    .ctrl_out(ctrl_out), .ctrl_oe(ctrl_oe), .level_code(level_code),
    .level_update(level_update));
  owlpr_host u_owlpr_host (.core_clk(core_clk), .dev_oe(ctrl_oe),
    .line(line));
  task automatic print_verdict();
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [4:0] e, g);
    checks++;
    if (g !== e) bad_count++;
    if (g !== e) $display("CHECK FAILED %s expected %h seen %h", n, e, g);
  endtask
  // Every frame ends with a reply probe, which also spaces the frames.
  task automatic frame(input logic [7:0] a, d, input int nd, lo);
    u_owlpr_host.send_byte(a, 8, lo);
    u_owlpr_host.send_byte(d, nd, lo);
    u_owlpr_host.ack(seen);
  endtask
  task automatic t_reset();
    check("level", 5'h1F, level_code);
  endtask
  task automatic t_plain();
    frame(8'h5A, 8'h0A, 8, 320);
    check("level", 5'h0A, level_code);
    check("reply", 5'h01, {4'h0, seen});
  endtask
  task automatic t_ack();
    frame(8'h5A, 8'h95, 8, 320);
    check("level", 5'h15, level_code);
    check("reply", 5'h00, {4'h0, seen});
    check("release", 5'h01, {4'h0, line});
  endtask
  task automatic t_bad();
    frame(8'h5B, 8'h84, 8, 320);
    check("level", 5'h15, level_code);
    check("reply", 5'h01, {4'h0, seen});
    frame(8'h5A, 8'h8C, 7, 320);
    check("level", 5'h15, level_code);
    check("reply", 5'h01, {4'h0, seen});
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 97000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    #1 srst = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 t_reset();
    t_plain();
    t_ack();
    t_bad();
    print_verdict();
  end
endmodule
`default_nettype wire
